// File: logic/dio_cfg.svh
// Register offsets, field positions and zero constants for the I/O register port.
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
`define DIO_OFF_AN_LO   8'hD0
`define DIO_OFF_AN_HI   8'hD4
`define DIO_OFF_DIG_LO  8'hD8
`define DIO_OFF_DIG_HI  8'hDC
`define DIO_OFF_GAIN    8'hE0
`define DIO_OFF_MODE    8'hE4
`define DIO_OFF_TRIG    8'hE8
`define DIO_OFF_STAT    8'hEC
`define DIO_GAIN_LSB    0
`define DIO_GAIN_MSB    1
`define DIO_CHAN_LSB    2
`define DIO_CHAN_MSB    5
`define DIO_RDY_BIT     0
`define DIO_ZERO8       8'h00
`define DIO_ZERO4       4'h0
`define DIO_ZERO12      12'h000
`define DIO_ZERO16      16'h0000
`endif

// File: logic/dio_pkg.sv
// Types shared by the I/O register port.
package dio_pkg;
    typedef enum logic [1:0] {DIO_GAIN_X1, DIO_GAIN_X2, DIO_GAIN_X3, DIO_GAIN_X4} dio_gain_t;
    typedef enum logic {DIO_CONV_IDLE, DIO_CONV_BUSY} dio_conv_t;
endpackage

// File: logic/dio_port.sv
// Host byte register port: digital I/O words, analog output latch, gain and channel select.
// Functional notes
// RQ1: Sixteen discrete inputs form one input word.
// RQ2: Reads at d8/dc return input low/high bytes.
// RQ3: Writes at d8/dc load output low/high bytes.
// RQ4: Same offset reads and writes different registers.
// RQ5: Offset e0 write-only gain and channel fields.
// RQ6: Single-ended uses all four select bits.
// RQ7: Differential uses select bits two to zero.
// RQ8: Gain code selects four ascending gain steps.
// RQ9: Host waits gain settling before converting.
// RQ10: Write at e8 triggers a conversion.
// RQ11: Analog output latch updates on high byte.
// RQ12: Ready bit set when conversion completes.
// RQ13: Unused high bits read zero; latches hold.
`include "dio_cfg.svh"
module dio_port
    import dio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    input  wire logic [15:0] discrete_inputs,
    output logic      [15:0] dig_out,
    output logic      [11:0] ana_out,
    input  wire logic        diff_mode,
    output logic      [3:0]  ana_chan,
    output logic      [1:0]  gain_code,
    output logic      [7:0]  mode_ctrl,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_result
);
    typedef struct packed {
        logic [7:0]  rdata;
        logic [15:0] dout;
        logic [7:0]  ao_lo;
        logic [11:0] ao;
        logic [3:0]  chan;
        logic [1:0]  gain;
        logic [7:0]  mode;
        logic        start;
        logic        ready;
        logic [11:0] result;
        logic [3:0]  chan_eff;
        dio_conv_t   conv;
    } dio_st_t;

    dio_st_t     st_q;
    dio_st_t     st_d;
    logic [15:0] din_sync;

    // Pins are asynchronous to the host clock.
    dio_sync #(.W(16)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (discrete_inputs),
        .dout (din_sync)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    always_comb begin
        st_d       = st_q;
        st_d.start = 1'b0;
        if (conv_done && st_q.conv == DIO_CONV_BUSY) begin
            st_d.ready  = 1'b1; // RQ12
            st_d.result = conv_result;
            st_d.conv   = DIO_CONV_IDLE;
        end
        if (wr_stb) begin
            unique case (1'b1)
                hit(addr, `DIO_OFF_AN_LO): begin
                    st_d.ao_lo = wdata; // RQ4
                end
                hit(addr, `DIO_OFF_AN_HI): begin
                    st_d.ao = {wdata[3:0], st_q.ao_lo}; // RQ11 RQ13
                end
                hit(addr, `DIO_OFF_DIG_LO): begin
                    st_d.dout[7:0] = wdata; // RQ3
                end
                hit(addr, `DIO_OFF_DIG_HI): begin
                    st_d.dout[15:8] = wdata; // RQ3
                end
                hit(addr, `DIO_OFF_GAIN): begin
                    st_d.gain = wdata[`DIO_GAIN_MSB:`DIO_GAIN_LSB]; // RQ5 RQ8
                    st_d.chan = wdata[`DIO_CHAN_MSB:`DIO_CHAN_LSB]; // RQ5
                end
                hit(addr, `DIO_OFF_MODE): begin
                    st_d.mode = wdata;
                end
                hit(addr, `DIO_OFF_TRIG): begin
                    // A new trigger restarts; ready drops until the result lands.
                    st_d.start = 1'b1; // RQ10
                    st_d.ready = 1'b0;
                    st_d.conv  = DIO_CONV_BUSY;
                end
                default: begin
                end
            endcase
        end
        // Differential pairs ignore the top select bit.
        st_d.chan_eff = diff_mode ? {1'b0, st_d.chan[2:0]} : st_d.chan; // RQ6 RQ7
        st_d.rdata = `DIO_ZERO8;
        if (rd_stb) begin
            unique case (1'b1)
                hit(addr, `DIO_OFF_AN_LO):  st_d.rdata = st_q.result[7:0]; // RQ4
                hit(addr, `DIO_OFF_AN_HI):  st_d.rdata = {`DIO_ZERO4, st_q.result[11:8]}; // RQ13
                hit(addr, `DIO_OFF_DIG_LO): st_d.rdata = din_sync[7:0]; // RQ1 RQ2
                hit(addr, `DIO_OFF_DIG_HI): st_d.rdata = din_sync[15:8]; // RQ2
                hit(addr, `DIO_OFF_STAT):   st_d.rdata = {7'h00, st_q.ready}; // RQ12
                default:                    st_d.rdata = `DIO_ZERO8; // RQ5
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata      = st_q.rdata;
    assign dig_out    = st_q.dout;
    assign ana_out    = st_q.ao;
    assign ana_chan   = st_q.chan_eff;
    assign gain_code  = st_q.gain;
    assign mode_ctrl  = st_q.mode;
    assign conv_start = st_q.start;

    property p_do_lo;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_DIG_LO |=> dig_out[7:0] == $past(wdata);
    endproperty
    a_do_lo: assert property (p_do_lo) else $error("low output byte not loaded"); // RQ3

    property p_do_hi;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_DIG_HI |=> dig_out[15:8] == $past(wdata);
    endproperty
    a_do_hi: assert property (p_do_hi) else $error("high output byte not loaded"); // RQ3

    property p_di_rd;
        @(posedge clk) disable iff (rst)
        rd_stb && addr == `DIO_OFF_DIG_HI |=> rdata == $past(din_sync[15:8]);
    endproperty
    a_di_rd: assert property (p_di_rd) else $error("input high byte wrong"); // RQ2

    property p_ao_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && addr == `DIO_OFF_AN_HI) |=> $stable(ana_out);
    endproperty
    a_ao_hold: assert property (p_ao_hold) else $error("analog latch moved early"); // RQ11

    property p_ao_upd;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_AN_HI |=> ana_out[11:8] == $past(wdata[3:0]);
    endproperty
    a_ao_upd: assert property (p_ao_upd) else $error("analog high nibble wrong"); // RQ11

    property p_gain;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_GAIN |=> gain_code == $past(wdata[1:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not loaded"); // RQ5

    property p_diff;
        @(posedge clk) disable iff (rst)
        diff_mode && $stable(diff_mode) |-> !ana_chan[3];
    endproperty
    a_diff: assert property (p_diff) else $error("differential select uses bit 3"); // RQ7

    property p_trig;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_TRIG |=> conv_start ##1 !conv_start;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse wrong"); // RQ10

    property p_stat_hi;
        @(posedge clk) disable iff (rst)
        rd_stb && addr != `DIO_OFF_DIG_LO && addr != `DIO_OFF_DIG_HI
            && addr != `DIO_OFF_AN_LO |=> rdata[7:4] == `DIO_ZERO4;
    endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("upper bits not zero"); // RQ13

    property p_di_lo;
        @(posedge clk) disable iff (rst)
        rd_stb && addr == `DIO_OFF_DIG_LO |=> rdata == $past(din_sync[7:0]);
    endproperty
    a_di_lo: assert property (p_di_lo) else $error("input low byte wrong"); // RQ2

    property p_rsv_rd;
        @(posedge clk) disable iff (rst)
        rd_stb && (addr == `DIO_OFF_GAIN || addr == `DIO_OFF_TRIG) |=> rdata == `DIO_ZERO8;
    endproperty
    a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read not zero"); // RQ5

    property p_single;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_GAIN && !diff_mode
            |=> ana_chan == $past(wdata[`DIO_CHAN_MSB:`DIO_CHAN_LSB]);
    endproperty
    a_single: assert property (p_single) else $error("single-ended select lost a bit"); // RQ6

    // A trigger in the same cycle as a done pulse wins, so it is left out here.
    property p_rdy;
        @(posedge clk) disable iff (rst)
        conv_done && st_q.conv == DIO_CONV_BUSY && !(wr_stb && addr == `DIO_OFF_TRIG)
            |=> st_q.ready && st_q.result == $past(conv_result);
    endproperty
    a_rdy: assert property (p_rdy) else $error("result not latched on done"); // RQ12

    property p_trig_clr;
        @(posedge clk) disable iff (rst)
        wr_stb && addr == `DIO_OFF_TRIG |=> !st_q.ready;
    endproperty
    a_trig_clr: assert property (p_trig_clr) else $error("ready not cleared by trigger"); // RQ12

    property p_do_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && (addr == `DIO_OFF_DIG_LO || addr == `DIO_OFF_DIG_HI)) |=> $stable(dig_out);
    endproperty
    a_do_hold: assert property (p_do_hold) else $error("output latch moved unwritten"); // RQ13

    c_trig: cover property (@(posedge clk) wr_stb && addr == `DIO_OFF_TRIG);
    c_done: cover property (@(posedge clk) conv_done && st_q.conv == DIO_CONV_BUSY);
    c_ao:   cover property (@(posedge clk) wr_stb && addr == `DIO_OFF_AN_HI);
    c_diff: cover property (@(posedge clk) wr_stb && addr == `DIO_OFF_GAIN && diff_mode);
    c_stat: cover property (@(posedge clk) rd_stb && addr == `DIO_OFF_STAT);
endmodule

// File: logic/dio_sync.sv
// Three-stage synchroniser with agreement filter for a bus of pin inputs.
module dio_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } dio_sync_st_t;

    dio_sync_st_t st_q;
    dio_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // A bit changes only once the second and third stages agree.
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.o[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.o;
endmodule

// File: tb/daq_io_register_port_tb_top.sv
// Self-checking bench for the host byte register port.
module daq_io_register_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, diff_mode = 0;
    logic [7:0]  addr = 0, wdata = 0, rdata, mode_ctrl, b;
    logic [15:0] di = 0, dig_out, v;
    logic [11:0] ana_out, res = 0, conv_result, prev;
    logic [3:0]  ana_chan;
    logic [1:0]  gain_code;
    logic        conv_start, conv_done;
    int          n_mismatch = 0, cmp_count = 0;
    // Gain code 00 settles in 23 us, which is 2875 cycles of 8 ns.
    localparam int SETTLE_CYC = 2875;
    dio_port dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .wdata(wdata), .rdata(rdata), .discrete_inputs(di), .dig_out(dig_out),
        .ana_out(ana_out), .diff_mode(diff_mode), .ana_chan(ana_chan),
        .gain_code(gain_code), .mode_ctrl(mode_ctrl), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result));
    dio_conv_model conv_u (.clk(clk), .conv_start(conv_start), .next_res(res),
        .conv_done(conv_done), .conv_result(conv_result));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr_stb = 1;
        @(posedge clk);
        #1 wr_stb = 0;
    endtask
    // Read data stands for one cycle only, so it is taken right after its edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        rd_stb = 1;
        @(posedge clk);
        #1 rd_stb = 0;
        d = rdata;
    endtask
    function automatic logic [3:0] exp_chan(input logic [3:0] s, input logic dm);
        return dm ? {1'b0, s[2:0]} : s;
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200_000;
        n_mismatch++;
        conclude;
    end
    initial begin
        void'($urandom(32'h8915));
        repeat (16) @(posedge clk);
        #1 rst = 0;
        @(posedge clk);
        #1 chk("dig_out", 16'h0000, dig_out);
        chk("ana_out", 16'h0000, {4'h0, ana_out});
        prev = 12'h000;
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            wr(8'hd8, v[7:0]);
            wr(8'hdc, v[15:8]);
            chk("dig_out", v, dig_out);
            di = 16'($urandom);
            // Pin inputs pass a synchroniser, so give them time to settle.
            repeat (8) @(posedge clk);
            rd(8'hd8, b);
            chk("di_lo", {8'h00, di[7:0]}, {8'h00, b});
            rd(8'hdc, b);
            chk("di_hi", {8'h00, di[15:8]}, {8'h00, b});
            chk("dig_keep", v, dig_out);
            v = 16'($urandom);
            wr(8'hd0, v[7:0]);
            chk("ana_hold", {4'h0, prev}, {4'h0, ana_out});
            wr(8'hd4, {4'hf, v[11:8]});
            chk("ana_out", {4'h0, v[11:0]}, {4'h0, ana_out});
            prev = v[11:0];
            diff_mode = i[0];
            v[5] = i[1];
            wr(8'he0, v[7:0]);
            chk("gain", {14'h0000, v[1:0]}, {14'h0000, gain_code});
            chk("chan", {12'h000, exp_chan(v[5:2], i[0])}, {12'h000, ana_chan});
            rd(8'he0, b);
            chk("rd_e0", 16'h0000, {8'h00, b});
            wr(8'he4, v[15:8]);
            chk("mode", {8'h00, v[15:8]}, {8'h00, mode_ctrl});
            wr(8'hc0, 8'hff);
            chk("unmapped", {4'h0, prev}, {4'h0, ana_out});
        end
        $display("test writes and reads done");
        wr(8'he0, 8'h00);
        repeat (SETTLE_CYC) @(posedge clk);
        #1;
        for (int i = 0; i < 3; i++) begin
            res = 12'($urandom);
            wr(8'he8, 8'h00);
            chk("start", 16'h0001, {15'h0000, conv_start});
            rd(8'hec, b);
            chk("busy", 16'h0000, {15'h0000, b[0]});
            repeat (8) @(posedge clk);
            rd(8'hec, b);
            chk("ready", 16'h0001, {15'h0000, b[0]});
            rd(8'hd0, b);
            chk("res_lo", {8'h00, res[7:0]}, {8'h00, b});
            rd(8'hd4, b);
            chk("res_hi", {12'h000, res[11:8]}, {8'h00, b});
        end
        $display("test conversion done");
        conclude;
    end
endmodule

// File: tb/dio_conv_model.sv
// Converter stand-in that answers each start pulse seen while idle with a done pulse and a result.
module dio_conv_model (
    input  wire logic        clk,
    input  wire logic        conv_start,
    input  wire logic [11:0] next_res,
    output logic             conv_done,
    output logic      [11:0] conv_result
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        conv_done = 1'b0;
        conv_result = 12'h000;
        forever begin
            @(posedge clk);
            #1;
            if (conv_start) begin
                repeat (5) @(posedge clk);
                #1 conv_done = 1'b1;
                conv_result = next_res;
                @(posedge clk);
                #1 conv_done = 1'b0;
                // The result is only valid beside the done pulse, so it is scrambled after.
                conv_result = ~next_res;
            end
        end
    end
endmodule
